/* bsc_strap_config.sv */
`timescale 1ns/100ps
// Overview of operation
// - Inhibit strap one skips EEPROM boot load
// - Inhibit strap ignored after sampling, slave untouched
// - Multibyte strap selects peripheral addressing width
// - Slave straps form slave address low bits
// - Software may overwrite slave address low bits
// - Select strap reuses slave straps for EEPROM
// - Select off forces EEPROM low bits zero
// - Software may overwrite EEPROM address low bits
// - Hard reset asynchronous, active low, whole block
module bsc_strap_config
    import bsc_pkg::*;
(
    // Clock and hard reset
    input wire logic clk,
    input wire logic rst_b,
    // Strap pins
    input wire bsc_straps_t straps,
    // Software overrides, write strobes are one-cycle pulses
    input wire bsc_sw_t sw,
    // Configuration out
    output bsc_cfg_t cfg,
    output logic cfg_valid
);
    // Consumers must wait for cfg_valid: before capture the boot enable
    // reads 0, which would otherwise look like a deliberately skipped load.
    // Straps are taken once, a few cycles into the board's hold window, so a
    // slowly settling pin gets margin on both sides of the sample point.

    // All state of this module
    typedef struct packed {
        bsc_cfg_t cfg;
        logic valid;
    } bsc_top_t;

    // Held configuration and its valid flag
    bsc_top_t cur;
    // Value the flops take at the next edge
    bsc_top_t next_cur;
    // One-cycle capture pulse from the sequencer
    logic take;
    // Sequencer finished; only software may change bits now
    logic done;

    // Sequencer picks the one capture cycle
    // Kept apart so the sample point can move without touching the capture
    bsc_sampler u_sampler (
        .clk(clk),
        .rst_b(rst_b),
        .take(take),
        .done(done)
    );

    // EEPROM low bits from straps
    function automatic logic [1:0] ee_low_of(input logic sel, input logic [1:0] sa);
        return sel ? sa : EE_LOW_DEFAULT;
    endfunction

    // Next-state: capture once, then only software may change bits
    always_comb begin
        // Hold everything by default
        next_cur = cur;
        // Capture cycle: straps win over any write strobe in the same cycle
        if (take) begin
            next_cur.cfg.boot_load_en = ~straps.load_inhibit;
            next_cur.cfg.multibyte = straps.multibyte_addr_strap;
            next_cur.cfg.slave_addr_low = straps.slave_addr_low_straps;
            // Select strap decides where the EEPROM bits come from
            next_cur.cfg.ee_addr_low = ee_low_of(straps.eeprom_sel,
                                                 straps.slave_addr_low_straps);
            // Valid rises with the captured values, never before
            next_cur.valid = 1'b1;
        end else if (done) begin
            if (sw.slave_we) begin
                next_cur.cfg.slave_addr_low = sw.slave_low;
            end
            if (sw.ee_we) begin
                next_cur.cfg.ee_addr_low = sw.ee_low;
            end
        end
    end

    // asynchronous active-low reset of all state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            // Everything cleared; valid low until the next capture
            cur <= '{cfg: '{boot_load_en: 1'b0, multibyte: 1'b0,
                           slave_addr_low: ADDR_LOW_RST, ee_addr_low: ADDR_LOW_RST},
                     valid: 1'b0};
        end else begin
            // Advance to the next value
            cur <= next_cur;
        end
    end

    // Outputs come straight from the state flops, so they never glitch
    assign cfg = cur.cfg;
    // Valid qualifies every field; consumers ignore cfg while it is low
    assign cfg_valid = cur.valid;

    // Checks of the capture edge

    // Inhibit strap at the capture edge decides the boot load
    a_boot_inhibit: assert property (@(posedge clk) disable iff (!rst_b)
        take |=> cfg.boot_load_en == !$past(straps.load_inhibit))
        else $error("boot load enable wrong");

    // Boot enable and addressing width frozen once captured
    a_strap_ignored: assert property (@(posedge clk) disable iff (!rst_b)
        (cfg_valid && !take) |=> $stable(cfg.boot_load_en) && $stable(cfg.multibyte))
        else $error("strap changed after sampling");

    // Slave low bits still captured when the boot load is skipped
    a_slave_kept: assert property (@(posedge clk) disable iff (!rst_b)
        (take && straps.load_inhibit) |=>
            cfg.slave_addr_low == $past(straps.slave_addr_low_straps))
        else $error("slave bits lost with load skipped");

    // Multibyte strap picks the peripheral addressing width
    a_multibyte_mode: assert property (@(posedge clk) disable iff (!rst_b)
        take |=> cfg.multibyte == $past(straps.multibyte_addr_strap))
        else $error("multibyte mode wrong");

    // Slave low bits copied from the straps
    a_slave_low: assert property (@(posedge clk) disable iff (!rst_b)
        take |=> cfg.slave_addr_low == $past(straps.slave_addr_low_straps))
        else $error("slave low bits wrong");

    // Select strap on: EEPROM bits follow the slave straps
    a_ee_sel_on: assert property (@(posedge clk) disable iff (!rst_b)
        (take && straps.eeprom_sel) |=> cfg.ee_addr_low == $past(straps.slave_addr_low_straps))
        else $error("eeprom bits not from straps");

    // Select strap off: EEPROM bits forced to the default
    a_ee_sel_off: assert property (@(posedge clk) disable iff (!rst_b)
        (take && !straps.eeprom_sel) |=> cfg.ee_addr_low == EE_LOW_DEFAULT)
        else $error("eeprom bits not zero");

    // Checks of the software overrides

    // A slave write replaces the whole field
    a_slave_override: assert property (@(posedge clk) disable iff (!rst_b)
        (done && sw.slave_we) |=> cfg.slave_addr_low == $past(sw.slave_low))
        else $error("slave override lost");

    // Without a write the slave bits stay put
    a_slave_hold: assert property (@(posedge clk) disable iff (!rst_b)
        (cfg_valid && !sw.slave_we) |=> $stable(cfg.slave_addr_low))
        else $error("slave bits moved without a write");

    // A slave write in the capture cycle loses to the straps
    a_slave_refused: assert property (@(posedge clk) disable iff (!rst_b)
        (take && sw.slave_we) |=> cfg.slave_addr_low == $past(straps.slave_addr_low_straps))
        else $error("slave write taken during capture");

    // An EEPROM write replaces the whole field
    a_ee_override: assert property (@(posedge clk) disable iff (!rst_b)
        (done && sw.ee_we) |=> cfg.ee_addr_low == $past(sw.ee_low))
        else $error("eeprom override lost");

    // Without a write the EEPROM bits stay put
    a_ee_hold: assert property (@(posedge clk) disable iff (!rst_b)
        (cfg_valid && !sw.ee_we) |=> $stable(cfg.ee_addr_low))
        else $error("eeprom bits moved without a write");

    // An EEPROM write in the capture cycle loses to the straps
    a_ee_refused: assert property (@(posedge clk) disable iff (!rst_b)
        (take && sw.ee_we && !straps.eeprom_sel) |=> cfg.ee_addr_low == EE_LOW_DEFAULT)
        else $error("eeprom write taken during capture");

    // Coinciding strobes update both fields in one cycle
    a_both_writes: assert property (@(posedge clk) disable iff (!rst_b)
        (done && sw.slave_we && sw.ee_we) |=>
            {cfg.slave_addr_low, cfg.ee_addr_low} == {$past(sw.slave_low), $past(sw.ee_low)})
        else $error("coinciding writes not both applied");

    // Checks of the valid flag

    // Valid rises only right after the capture cycle
    a_valid_timing: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(cfg_valid) |-> $past(take))
        else $error("valid without capture");

    // Captured values stay valid until the next hard reset
    a_valid_stays: assert property (@(posedge clk) disable iff (!rst_b)
        cfg_valid |=> cfg_valid)
        else $error("valid dropped without reset");

    // Valid and the finished sequencer always agree
    a_valid_done: assert property (@(posedge clk) disable iff (!rst_b)
        cfg_valid == done)
        else $error("valid and sequencer disagree");

    // A second capture would reopen the straps
    a_no_second_take: assert property (@(posedge clk) disable iff (!rst_b)
        cfg_valid |-> !take)
        else $error("capture after valid");

    // Before capture all fields read their reset value, writes ignored
    a_zero_before_take: assert property (@(posedge clk) disable iff (!rst_b)
        !cfg_valid |-> (cfg == '0))
        else $error("field set before capture");

    // Main scenarios: skipped load, reused strap bits, each override, both at once
    c_boot_skip: cover property (@(posedge clk) disable iff (!rst_b)
        take && straps.load_inhibit);
    c_ee_sel: cover property (@(posedge clk) disable iff (!rst_b)
        take && straps.eeprom_sel);
    c_sw_slave: cover property (@(posedge clk) disable iff (!rst_b)
        done && sw.slave_we);
    c_sw_ee: cover property (@(posedge clk) disable iff (!rst_b)
        done && sw.ee_we);
    c_sw_both: cover property (@(posedge clk) disable iff (!rst_b)
        done && sw.slave_we && sw.ee_we);
endmodule

/* bsc_pkg.sv */
package bsc_pkg;
    // Cycles after reset release the board keeps the straps steady
    localparam int unsigned STRAP_HOLD_CYC = 10;
    // Sample point sits inside the hold window, a few cycles in for settling
    localparam int unsigned SAMPLE_CYC = 5;
    // Width of the sampling counter
    localparam int unsigned CNT_W = 4;
    // Low address bits forced when the EEPROM select strap is off
    localparam logic [1:0] EE_LOW_DEFAULT = 2'h0;
    // Reset values of held straps
    localparam logic [1:0] ADDR_LOW_RST = 2'h0;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam logic [CNT_W-1:0] CNT_SAMPLE = 4'h5;

    // Sampler sequencer states, Gray coded
    typedef enum logic [1:0] {
        BSC_WAIT = 2'b00,
        BSC_TAKE = 2'b01,
        BSC_DONE = 2'b11
    } bsc_state_t;

    // Raw strap pins as they arrive
    typedef struct packed {
        logic load_inhibit;
        logic multibyte_addr_strap;
        logic [1:0] slave_addr_low_straps;
        logic eeprom_sel;
    } bsc_straps_t;

    // Software override of address low bits
    typedef struct packed {
        logic slave_we;
        logic [1:0] slave_low;
        logic ee_we;
        logic [1:0] ee_low;
    } bsc_sw_t;

    // Configuration handed to the I2C engine
    typedef struct packed {
        logic boot_load_en;
        logic multibyte;
        logic [1:0] slave_addr_low;
        logic [1:0] ee_addr_low;
    } bsc_cfg_t;
endpackage

/* bsc_sampler.sv */
`timescale 1ns/100ps
// Counts from reset release and fires one capture pulse
module bsc_sampler
    import bsc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Capture control
    output logic take,
    output logic done
);
    // All state of the sequencer
    typedef struct packed {
        bsc_state_t st;
        logic [CNT_W-1:0] cnt;
    } bsc_smp_t;

    bsc_smp_t cur;
    bsc_smp_t next_cur;

    // Next-state logic
    always_comb begin
        next_cur = cur;
        case (cur.st)
            // Count cycles since release
            BSC_WAIT: begin
                next_cur.cnt = cur.cnt + CNT_ONE;
                if (cur.cnt == CNT_SAMPLE - CNT_ONE) begin
                    next_cur.st = BSC_TAKE;
                end
            end
            // Capture happens in this single cycle
            BSC_TAKE: begin
                next_cur.st = BSC_DONE;
            end
            // Stay until next hard reset
            BSC_DONE: begin
                next_cur.st = BSC_DONE;
            end
            default: begin
                next_cur.st = BSC_DONE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cur <= '{st: BSC_WAIT, cnt: CNT_ZERO};
        end else begin
            cur <= next_cur;
        end
    end

    assign take = (cur.st == BSC_TAKE);
    assign done = (cur.st == BSC_DONE);

    // Capture falls inside the board hold window
    a_take_in_window: assert property (@(posedge clk) disable iff (!rst_b)
        take |-> (cur.cnt == CNT_SAMPLE) && (SAMPLE_CYC < STRAP_HOLD_CYC))
        else $error("capture outside hold window");
    // One capture only
    a_take_once: assert property (@(posedge clk) disable iff (!rst_b)
        take |=> done [*8])
        else $error("capture repeated");
endmodule

/* bsc_board_model.sv */
`timescale 1ns/100ps
// Board straps: steady through reset and the hold window, scrambled later
module bsc_board_model
    import bsc_pkg::*;
(
    // Clock and hard reset
    input wire logic clk,
    input wire logic rst_b,
    // Wanted strap levels
    input wire bsc_straps_t level,
    // Strap pins and test reset
    output bsc_straps_t straps,
    output logic trst_b
);
    // Edges since release, saturating so it never wraps
    logic [3:0] cnt;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 4'h0;
        end else if (cnt != 4'hF) begin
            cnt <= cnt + 4'h1;
        end
    end
    // Inverse after the window, so a late sample shows as a wrong value
    assign straps = (rst_b && cnt >= 4'hA) ? ~level : level;
    // test reset held with hard reset
    assign trst_b = rst_b;
endmodule

/* tb_bsc_strap_config.sv */
`timescale 1ns/100ps
// Self-checking bench for the strap configuration block
module tb_bsc_strap_config;
    import bsc_pkg::*;
    `define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
        $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    bsc_straps_t level = '0;
    bsc_straps_t straps;
    logic trst_b;
    bsc_sw_t sw = '0;
    bsc_cfg_t cfg;
    logic cfg_valid;
    int error_cnt = 0;
    int check_count = 0;
    // Clock at 20 MHz
    always #25 clk = ~clk;
    // Board side
    bsc_board_model board (.clk(clk), .rst_b(rst_b), .level(level), .straps(straps),
        .trst_b(trst_b));
    bsc_strap_config DUT (.clk(clk), .rst_b(rst_b), .straps(straps), .sw(sw), .cfg(cfg),
        .cfg_valid(cfg_valid));
    // Verdict and end of run
    task conclude;
        if (error_cnt == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Reset with given straps; strobes raised in the capture cycle must be refused
    task boot(input bsc_straps_t v);
        int i;
        @(posedge clk);
        rst_b <= 1'b0;
        level <= v;
        #1 `CHK({cfg, cfg_valid}, 7'h00)
        `CHK(trst_b, 1'b0)
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        // Strobes stand at the sixth edge after release, the capture edge
        repeat (5) @(posedge clk);
        sw <= '{1'b1, 2'h1, 1'b1, 2'h1};
        @(posedge clk);
        sw <= '0;
        for (i = 0; i < 12 && cfg_valid !== 1'b1; i++) @(posedge clk);
        #1 `CHK(cfg_valid, 1'b1)
    endtask
    // Capture, then straps scramble and the held values stay
    task t_capture(input bsc_straps_t v, input bsc_cfg_t exp);
        boot(v);
        `CHK(cfg, exp)
        repeat (15) @(posedge clk);
        #1 `CHK(cfg, exp)
    endtask
    // Coinciding then back to back overrides
    task t_override;
        @(posedge clk);
        sw <= '{1'b1, 2'h1, 1'b1, 2'h3};
        @(posedge clk);
        sw <= '{1'b1, 2'h2, 1'b0, 2'h0};
        #1 `CHK({cfg.slave_addr_low, cfg.ee_addr_low}, 4'h7)
        @(posedge clk);
        sw <= '0;
        #1 `CHK({cfg.slave_addr_low, cfg.ee_addr_low}, 4'hB)
    endtask
    // Hang guard, far beyond the expected run of about 180 cycles
    initial begin
        #100000;
        error_cnt++;
        conclude;
    end
    // Main sequence
    initial begin
        t_capture('{1'b1, 1'b1, 2'h2, 1'b1}, '{1'b0, 1'b1, 2'h2, 2'h2});
        t_capture('{1'b0, 1'b0, 2'h3, 1'b0}, '{1'b1, 1'b0, 2'h3, 2'h0});
        t_override;
        t_capture('{1'b0, 1'b1, 2'h1, 1'b1}, '{1'b1, 1'b1, 2'h1, 2'h1});
        t_capture('{1'b1, 1'b0, 2'h0, 1'b1}, '{1'b0, 1'b0, 2'h0, 2'h0});
        conclude;
    end
endmodule
